// File: core/sapf_pkg.sv
// Purpose: Shared constants and types of the serial audio port block
// Assumes: APB slave, 32-bit data, byte address is four times the index
// Notes:   Field positions and reset values live here only
package sapf_pkg;

    typedef logic [7:0]  addr_t;
    typedef logic [31:0] word_t;
    typedef logic [23:0] sample_t;

    // Register indices and byte addresses
    localparam logic [7:0] IDX_CTRL_ONE = 8'h04;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h05;
    localparam logic [7:0] IDX_STATUS   = 8'h06;
    localparam logic [7:0] IDX_LEFT     = 8'h07;
    localparam logic [7:0] IDX_RIGHT    = 8'h08;
    localparam logic [7:0] IDX_SENSE    = 8'h09;
    localparam addr_t ADDR_CTRL_ONE = addr_t'({IDX_CTRL_ONE, 2'b00});
    localparam addr_t ADDR_CTRL_TWO = addr_t'({IDX_CTRL_TWO, 2'b00});
    localparam addr_t ADDR_STATUS   = addr_t'({IDX_STATUS, 2'b00});
    localparam addr_t ADDR_LEFT     = addr_t'({IDX_LEFT, 2'b00});
    localparam addr_t ADDR_RIGHT    = addr_t'({IDX_RIGHT, 2'b00});
    localparam addr_t ADDR_SENSE    = addr_t'({IDX_SENSE, 2'b00});

    // Reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h08;
    localparam word_t      SENSE_RST    = 32'h0000_0000;

    // Field positions in the first control register
    localparam int unsigned POS_SAMPLE_FALL = 0;
    localparam int unsigned POS_WIDTH_LO    = 1;
    localparam int unsigned POS_FS_STYLE    = 3;
    localparam int unsigned POS_DELAY_FMT   = 4;
    localparam int unsigned POS_MULTISLOT   = 5;
    localparam int unsigned POS_DENSITY     = 6;
    // Field position in the second control register
    localparam int unsigned POS_DRIVE       = 6;

    // Slot widths and counts
    localparam logic [6:0] SLOT_W32  = 7'h20;
    localparam logic [6:0] SLOT_W48  = 7'h30;
    localparam logic [6:0] SLOT_W64  = 7'h40;
    localparam logic [6:0] CNT_MAX   = 7'h7f;
    localparam logic [4:0] WORD_BITS = 5'h18;

    typedef struct packed {
        logic       sample_fall;
        logic [1:0] chip_slot_width;
        logic       frame_sync_style;
        logic       data_delay_format;
        logic       stereo_or_multislot_select;
        logic       density_modulation_select;
        logic       sense_out_drive_strength;
    } sapf_cfg_t;

endpackage : sapf_pkg

// File: core/sapf_if.sv
// Purpose: Carrier between register slave and framing core
// Assumes: Single clock domain on sys_clk
// Notes:   Registers drive configuration, core drives captured state
`timescale 1ns/100ps
interface sapf_if;
    import sapf_pkg::*;
    sapf_cfg_t  cfg;
    word_t      sense_word;
    sample_t    left;
    sample_t    right;
    logic [7:0] frames;
    modport regs (output cfg, output sense_word, input left, input right, input frames);
    modport core (input cfg, input sense_word, output left, output right, output frames);
endinterface : sapf_if

// File: core/sapf_sync.sv
// Purpose: Two-stage synchroniser of link pins and bit clock edge finder
// Assumes: Link pins asynchronous to sys_clk, bit clock well below sys_clk/4
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module sapf_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic bit_clock,
    input  wire logic frame_sync,
    input  wire logic serial_audio_in,
    output logic      clk_rise,
    output logic      clk_fall,
    output logic      fs_sync,
    output logic      din_sync
);
    import sapf_pkg::*;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic       clk_prev;
    } sapf_sync_t;

    sapf_sync_t q, d;

    // Stage one to stage two, edge history from stage two
    always_comb begin
        d          = q;
        d.s1       = {bit_clock, frame_sync, serial_audio_in};
        d.s2       = q.s1;
        d.clk_prev = q.s2[2];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Edges and aligned data
    assign clk_rise = q.s2[2] & ~q.clk_prev;
    assign clk_fall = ~q.s2[2] & q.clk_prev;
    assign fs_sync  = q.s2[1];
    assign din_sync = q.s2[0];

endmodule : sapf_sync

// File: core/sapf_apb.sv
// Purpose: APB register slave for the serial audio port
// Assumes: One wait state on every access, 32-bit aligned words
// Notes:   Unmapped or unaligned access answers with pslverr and zero data
`timescale 1ns/100ps
module sapf_apb (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire sapf_pkg::addr_t paddr,
    input  wire sapf_pkg::word_t pwdata,
    output sapf_pkg::word_t      prdata,
    output logic                 pready,
    output logic                 pslverr,
    sapf_if.regs                 io
);
    import sapf_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        word_t      sense;
        word_t      rdata;
        logic       rdy;
        logic       err;
    } sapf_apb_t;

    localparam sapf_apb_t APB_RST = '{CTRL_ONE_RST, CTRL_TWO_RST, SENSE_RST,
                                      32'h0000_0000, 1'b0, 1'b0};

    sapf_apb_t q, d;

    // Address decode used for the error answer; read data has its own case
    function automatic logic is_mapped(input addr_t a);
        return (a == ADDR_CTRL_ONE) || (a == ADDR_CTRL_TWO) || (a == ADDR_STATUS) ||
               (a == ADDR_LEFT) || (a == ADDR_RIGHT) || (a == ADDR_SENSE);
    endfunction : is_mapped

    // Access phase: answer in second cycle, write at the completing edge
    always_comb begin
        d     = q;
        d.rdy = psel & penable & ~q.rdy;
        d.err = 1'b0;
        if (psel && penable && !q.rdy) begin
            d.err   = ~is_mapped(paddr);
            d.rdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL_ONE: d.rdata = {24'h00_0000, q.ctrl_one};
                ADDR_CTRL_TWO: d.rdata = {24'h00_0000, q.ctrl_two};
                ADDR_STATUS:   d.rdata = {24'h00_0000, io.frames};
                ADDR_LEFT:     d.rdata = {8'h00, io.left};
                ADDR_RIGHT:    d.rdata = {8'h00, io.right};
                ADDR_SENSE:    d.rdata = q.sense;
                default:       d.rdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && q.rdy && pwrite) begin
            unique case (paddr)
                ADDR_CTRL_ONE: d.ctrl_one = pwdata[7:0];
                ADDR_CTRL_TWO: d.ctrl_two = pwdata[7:0];
                ADDR_SENSE:    d.sense    = pwdata;
                default:       d.sense    = q.sense;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= APB_RST;
        end else begin
            q <= d;
        end
    end

    // Bus answer from flops
    assign prdata  = q.rdata;
    assign pready  = q.rdy;
    assign pslverr = q.err;

    // Configuration fields toward the core
    assign io.cfg.sample_fall                = q.ctrl_one[POS_SAMPLE_FALL];
    assign io.cfg.chip_slot_width            = q.ctrl_one[POS_WIDTH_LO +: 2];
    assign io.cfg.frame_sync_style           = q.ctrl_one[POS_FS_STYLE];
    assign io.cfg.data_delay_format          = q.ctrl_one[POS_DELAY_FMT];
    assign io.cfg.stereo_or_multislot_select = q.ctrl_one[POS_MULTISLOT];
    assign io.cfg.density_modulation_select  = q.ctrl_one[POS_DENSITY];
    assign io.cfg.sense_out_drive_strength   = q.ctrl_two[POS_DRIVE];
    assign io.sense_word                     = q.sense;

endmodule : sapf_apb

// File: core/sapf_top.sv
// Purpose: Slave serial audio input port with format configuration
// Assumes: Host drives bit clock, frame sync and data; sys_clk at 250 MHz
// Notes:   Bit clock is sampled and its edges found on sys_clk
//
// Contract
// - Sampling bit one: capture on falling edge
// - Width code sets chip slot 32/48/64
// - Stereo or single chip: any frame length
// - Style zero: low is left, pulsed sync
// - Style one: high is left, half-duty sync
// - Format zero: data one cycle after edge
// - Format one: data at sync edge
// - Mode bit: stereo zero, multislot one
// - Density bit: input and sense as PDM
// - Control two bit six: sense drive strength
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module sapf_top (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire sapf_pkg::addr_t paddr,
    input  wire sapf_pkg::word_t pwdata,
    output sapf_pkg::word_t      prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            bit_clock,
    input  wire logic            frame_sync,
    input  wire logic            serial_audio_in,
    output logic                 sense_data_out,
    output logic                 sense_out_drive_strength
);
    import sapf_pkg::*;

    typedef struct packed {
        logic       fs_prev;
        logic       chan;
        logic [6:0] cnt;
        logic [4:0] wb;
        sample_t    shift;
        sample_t    left;
        sample_t    right;
        logic [7:0] frames;
        word_t      sense;
        logic       sdo;
        logic       drive;
    } sapf_core_t;

    sapf_if     io ();
    sapf_core_t q, d;
    logic       clk_rise;
    logic       clk_fall;
    logic       fs;
    logic       din;
    logic       samp;
    logic       drv;
    logic       nf;
    logic [6:0] width;
    logic [6:0] half;

    // Bit clock cycles per chip from the width code
    function automatic logic [6:0] slot_width(input logic [1:0] code);
        unique case (code)
            2'b00:   return SLOT_W32;
            2'b01:   return SLOT_W48;
            default: return SLOT_W64;
        endcase
    endfunction : slot_width

    // Link pins through the synchroniser
    sapf_sync u_sync (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .bit_clock       (bit_clock),
        .frame_sync      (frame_sync),
        .serial_audio_in (serial_audio_in),
        .clk_rise        (clk_rise),
        .clk_fall        (clk_fall),
        .fs_sync         (fs),
        .din_sync        (din)
    );

    // Register slave
    sapf_apb u_apb (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .io      (io.regs)
    );

    // Sampling and driving edges
    // falling edge select
    assign samp  = io.cfg.sample_fall ? clk_fall : clk_rise;
    assign drv   = io.cfg.sample_fall ? clk_rise : clk_fall;
    assign width = slot_width(io.cfg.chip_slot_width);
    assign half  = {1'b0, width[6:1]};
    // stereo sync uses falling edge too, multislot rising only
    assign nf    = io.cfg.stereo_or_multislot_select ? (fs & ~q.fs_prev)
                                                     : (fs ^ q.fs_prev);

    // Framing, capture and sense stream
    always_comb begin
        logic       take;
        logic [6:0] idx;
        d     = q;
        take  = 1'b0;
        idx   = q.cnt;
        d.drive = io.cfg.sense_out_drive_strength;
        if (samp) begin
            d.fs_prev = fs;
            if (io.cfg.density_modulation_select) begin
                d.shift = {q.shift[22:0], din};
                d.wb    = q.wb + 5'h01;
                if (q.wb == WORD_BITS - 5'h01) begin
                    d.left   = d.shift;
                    d.wb     = 5'h00;
                    d.frames = q.frames + 8'h01;
                end
            end else begin
                if (nf) begin
                    d.chan   = io.cfg.stereo_or_multislot_select ? 1'b0
                                                                : (fs ^ io.cfg.frame_sync_style);
                    d.wb     = 5'h00;
                    d.frames = q.frames + 8'h01;
                    d.sense  = io.sense_word;
                    idx      = 7'h00;
                    take     = io.cfg.data_delay_format;
                end else begin
                    take = 1'b1;
                end
                d.cnt = take ? ((idx == CNT_MAX) ? idx : idx + 7'h01) : 7'h00;
                if (take && io.cfg.stereo_or_multislot_select) begin
                    if (idx >= width) begin
                        take = 1'b0;
                    end else if (idx == half) begin
                        d.chan = 1'b1;
                        d.wb   = 5'h00;
                    end
                end
                if (take && d.wb < WORD_BITS) begin
                    d.shift = {q.shift[22:0], din};
                    d.wb    = d.wb + 5'h01;
                    if (d.wb == WORD_BITS) begin
                        if (d.chan) begin
                            d.right = d.shift;
                        end else begin
                            d.left = d.shift;
                        end
                    end
                end
            end
        end
        if (drv) begin
            d.sdo   = q.sense[31];
            d.sense = io.cfg.density_modulation_select ? {q.sense[30:0], q.sense[31]}
                                                       : {q.sense[30:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs and captured state
    assign sense_data_out           = q.sdo;
    assign sense_out_drive_strength = q.drive;
    assign io.left                  = q.left;
    assign io.right                 = q.right;
    assign io.frames                = q.frames;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_fall_only_capture: assert property (
        clk_rise && io.cfg.sample_fall |=> $stable(q.shift))
        else $error("shift moved on rising edge with falling select");

    a_rise_only_capture: assert property (
        clk_fall && !io.cfg.sample_fall |=> $stable(q.shift))
        else $error("shift moved on falling edge with rising select");

    a_slot_half_switch: assert property (
        samp && !nf && io.cfg.stereo_or_multislot_select &&
        !io.cfg.density_modulation_select && q.cnt == half |=> q.chan && q.wb == 5'h01)
        else $error("second half of slot not started at half width");

    a_slot_beyond_width: assert property (
        samp && !nf && io.cfg.stereo_or_multislot_select &&
        !io.cfg.density_modulation_select && q.cnt >= width |=> $stable(q.shift))
        else $error("data taken beyond chip slot");

    a_stereo_any_len: assert property (
        samp && nf && !io.cfg.stereo_or_multislot_select &&
        !io.cfg.density_modulation_select |=> q.cnt <= 7'h01)
        else $error("stereo frame start not accepted");

    a_left_low_sync: assert property (
        samp && nf && !io.cfg.stereo_or_multislot_select && !io.cfg.frame_sync_style &&
        !io.cfg.density_modulation_select |=> q.chan == $past(fs))
        else $error("low sync not left channel");

    a_left_high_sync: assert property (
        samp && nf && !io.cfg.stereo_or_multislot_select && io.cfg.frame_sync_style &&
        !io.cfg.density_modulation_select |=> q.chan == !$past(fs))
        else $error("high sync not left channel");

    a_i2s_delay_one: assert property (
        samp && nf && !io.cfg.data_delay_format && !io.cfg.density_modulation_select
        |=> q.cnt == 7'h00 && $stable(q.shift))
        else $error("bit at sync edge taken in delayed format");

    a_lj_no_delay: assert property (
        samp && nf && io.cfg.data_delay_format && !io.cfg.density_modulation_select
        |=> q.cnt == 7'h01 && q.shift[0] == $past(din))
        else $error("bit at sync edge missed in justified format");

    a_frame_count_up: assert property (
        samp && nf && !io.cfg.density_modulation_select
        |=> q.frames == $past(q.frames) + 8'h01)
        else $error("frame start not counted");

    a_pdm_capture: assert property (
        samp && io.cfg.density_modulation_select |=> q.shift[0] == $past(din))
        else $error("density bit not captured");

    a_drive_follow: assert property (
        ##1 sense_out_drive_strength == $past(io.cfg.sense_out_drive_strength))
        else $error("drive strength not following register");

    c_stereo_frame: cover property (samp && nf && !io.cfg.stereo_or_multislot_select);
    c_tdm_right: cover property (samp && io.cfg.stereo_or_multislot_select && q.cnt == half);
    c_pdm_word: cover property (samp && io.cfg.density_modulation_select && q.wb == 5'h17);
    c_apb_write: cover property (psel && penable && pready && pwrite);

endmodule : sapf_top

// File: dv/sapf_host_model.sv
// Purpose: Behavioural audio host that drives the link of the serial port
// Assumes: Bit clock period 48 ns, clock held still between frames
// Notes:   Data line shows a changing pattern outside the word bits
`timescale 1ns/100ps
module sapf_host_model
    import sapf_pkg::*;
(
    output logic      bit_clock,
    output logic      frame_sync,
    output logic      serial_audio_in,
    input  wire logic sense_data_out
);
    import sapf_pkg::*;

    // Sense bits heard at sampling edges, and one 32-bit snapshot
    word_t heard;
    word_t seen;

    // Idle levels at start
    initial begin
        bit_clock       = 1'b0;
        frame_sync      = 1'b0;
        serial_audio_in = 1'b0;
    end

    // Bit at slot index k, toggling pattern outside the word
    function automatic logic pick(input sample_t w, input int k, input logic lj);
        int i;
        i = lj ? k : k - 1;
        if (i >= 0 && i < 24) return w[23-i];
        return k[0];
    endfunction : pick

    task automatic bit_out(input logic f, input logic d, input logic fs);
        serial_audio_in = d;
        frame_sync      = fs;
        #24 bit_clock = ~f;
        heard = {heard[30:0], sense_data_out};
        #24 bit_clock = f;
    endtask : bit_out

    // Park the clock on the launch level
    task automatic idle(input logic f);
        bit_clock = f;
        #48;
    endtask : idle

    task automatic stereo(input logic f, input logic s, input logic lj,
                          input sample_t l, input sample_t r, input int n);
        idle(f);
        bit_out(f, 1'b0, ~s);
        for (int k = 0; k < n; k++) bit_out(f, pick(l, k, lj), s);
        for (int k = 0; k < n; k++) bit_out(f, pick(r, k, lj), ~s);
        serial_audio_in = ~serial_audio_in;
    endtask : stereo

    task automatic tdm(input logic f, input logic s, input logic lj, input int w,
                       input sample_t l, input sample_t r);
        logic fs;
        int   lm;
        lm = lj ? 24 : 25;
        idle(f);
        bit_out(f, 1'b0, 1'b0);
        for (int k = 0; k < 2 * w; k++) begin
            // Whole sense word heard once slot bit 32 is sampled
            if (k == 33) seen = heard;
            fs = s ? (k < w) : (k == 0);
            if (k < lm || k < w / 2) bit_out(f, pick(l, k, lj), fs);
            else bit_out(f, pick(r, k - w / 2, lj), fs);
        end
        serial_audio_in = ~serial_audio_in;
    endtask : tdm

    // Density stream, rising sampling edge
    task automatic pdm(input sample_t w);
        idle(1'b0);
        for (int k = 0; k < 24; k++) bit_out(1'b0, w[23-k], 1'b0);
        serial_audio_in = ~serial_audio_in;
    endtask : pdm

endmodule : sapf_host_model

// File: dv/tb.sv
// Purpose: Self-checking bench of the serial audio port block
// Assumes: APB master here, host model on the link
// Notes:   Random words from a fixed seed, expectations from bench functions
`timescale 1ns/100ps
module tb;
    import sapf_pkg::*;

    logic    sys_clk;
    logic    rst_n;
    logic    psel;
    logic    penable;
    logic    pwrite;
    addr_t   paddr;
    word_t   pwdata;
    word_t   prdata;
    logic    pready;
    logic    pslverr;
    logic    bit_clock;
    logic    frame_sync;
    logic    serial_audio_in;
    logic    sense_data_out;
    logic    sense_out_drive_strength;
    int      fails;
    int      checks;
    int      cyc = 0;
    int      n;
    word_t   seed;
    word_t   rd;
    word_t   t;
    logic    er;
    logic    f;
    logic    s;
    logic    lj;
    logic [1:0] c;
    sample_t l;
    sample_t r;
    sample_t xl;
    sample_t xr;
    word_t   sw;

    sapf_top u_sapf_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_clock(bit_clock), .frame_sync(frame_sync),
        .serial_audio_in(serial_audio_in), .sense_data_out(sense_data_out),
        .sense_out_drive_strength(sense_out_drive_strength));

    sapf_host_model u_sapf_host_model (.bit_clock(bit_clock), .frame_sync(frame_sync),
        .serial_audio_in(serial_audio_in), .sense_data_out(sense_data_out));

    // System clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            results();
        end
    end

    function automatic word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic word_t ctrl(input logic f, input logic [1:0] c, input logic s,
                                   input logic lj, input logic ms, input logic pd);
        return word_t'({pd, ms, lj, s, c, f});
    endfunction : ctrl

    function automatic int wid(input logic [1:0] c);
        return (c == 2'b00) ? 32 : (c == 2'b01) ? 48 : 64;
    endfunction : wid

    task automatic chk(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input addr_t a, input word_t d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input addr_t a, input word_t exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        seed    = 32'h00014dc3;
        fails   = 0;
        checks  = 0;
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(ADDR_CTRL_ONE, 32'h00000000);
        rdchk(ADDR_CTRL_TWO, 32'h00000008);
        rdchk(ADDR_SENSE, 32'h00000000);
        chk({31'h0, sense_out_drive_strength}, 32'h00000000);
        apb(1'b1, ADDR_CTRL_TWO, 32'h00000048);
        rdchk(ADDR_CTRL_TWO, 32'h00000048);
        chk({31'h0, sense_out_drive_strength}, 32'h00000001);
        apb(1'b1, ADDR_CTRL_TWO, 32'h00000008);
        rdchk(ADDR_CTRL_TWO, 32'h00000008);
        chk({31'h0, sense_out_drive_strength}, 32'h00000000);
        apb(1'b0, 8'h40, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b1, ADDR_STATUS, 32'h000000ff);
        rdchk(ADDR_STATUS, 32'h00000000);
        // Density stream word
        t = rnd();
        l = t[23:0];
        apb(1'b1, ADDR_CTRL_ONE, ctrl(1'b0, 2'b00, 1'b0, 1'b0, 1'b0, 1'b1));
        u_sapf_host_model.pdm(l);
        repeat (8) @(posedge sys_clk);
        rdchk(ADDR_LEFT, {8'h00, l});
        rdchk(ADDR_STATUS, 32'h00000001);
        // Stereo frames, every edge, style and format
        for (int i = 0; i < 8; i++) begin
            f = i[0];
            s = i[1];
            lj = i[2];
            t = rnd();
            l = t[23:0];
            t = rnd();
            r = t[23:0];
            n = 25 + int'(t[27:24]);
            apb(1'b1, ADDR_CTRL_ONE, ctrl(f, t[29:28], s, lj, 1'b0, 1'b0));
            rdchk(ADDR_CTRL_ONE, ctrl(f, t[29:28], s, lj, 1'b0, 1'b0));
            u_sapf_host_model.stereo(f, s, lj, l, r, n);
            repeat (8) @(posedge sys_clk);
            rdchk(ADDR_LEFT, {8'h00, l});
            rdchk(ADDR_RIGHT, {8'h00, r});
        end
        xl = l;
        xr = r;
        // Multislot frames over every width code
        for (int i = 0; i < 8; i++) begin
            c = i[1:0];
            s = i[2];
            lj = i[0] ^ i[2];
            t = rnd();
            l = t[23:0];
            f = t[31];
            t = rnd();
            r = t[23:0];
            sw = rnd();
            // Halves of a 32-cycle slot hold no full word, both kept
            if (c != 2'b00) begin
                xl = l;
                xr = r;
            end
            apb(1'b1, ADDR_SENSE, sw);
            rdchk(ADDR_SENSE, sw);
            apb(1'b1, ADDR_CTRL_ONE, ctrl(f, c, s, lj, 1'b1, 1'b0));
            u_sapf_host_model.tdm(f, s, lj, wid(c), l, r);
            repeat (8) @(posedge sys_clk);
            rdchk(ADDR_LEFT, {8'h00, xl});
            rdchk(ADDR_RIGHT, {8'h00, xr});
            chk(u_sapf_host_model.seen, sw);
        end
        results();
    end

endmodule : tb
